/* rtl/fault_severity_indicator.sv */
// Design decisions made here: the AHB-Lite slave port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "fault_sev_defs.svh"

module fault_severity_indicator
  import fault_sev_pkg::*;
(
  // clock and reset
  input  wire logic                     mclk_in,
  input  wire logic                     sys_rst_in,
  // ahb-lite slave
  input  wire logic                     hsel_in,
  input  wire logic [31:0]              haddr_in,
  input  wire logic [1:0]               htrans_in,
  input  wire logic                     hwrite_in,
  input  wire logic [2:0]               hsize_in,
  input  wire logic [31:0]              hwdata_in,
  input  wire logic                     hready_in,
  output logic      [31:0]              hrdata_out,
  output logic                          hreadyout_out,
  output logic                          hresp_out,
  // fault detectors, asynchronous levels
  input  wire logic [`NUM_FAULTS-1:0]   fault_in,
  // lamps, relay contacts and output module command
  output indicator_t                    indicators_out
);

  ////////////////////////////////////////////////////////////////////////////
  // fault input synchroniser

  logic [`NUM_FAULTS-1:0] fault_meta_q;
  logic [`NUM_FAULTS-1:0] fault_q;

  always_ff @(posedge mclk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      fault_meta_q <= '0;
      fault_q      <= '0;
    end else begin
      fault_meta_q <= fault_in;
      fault_q      <= fault_meta_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // registers

  logic [2:0]               ctrl_q;
  logic [`NUM_POLICY-1:0]   policy_q;
  logic [`NUM_FAULTS-1:0]   log_q;
  logic                     wr_pend_q;
  logic [7:0]               wr_addr_q;
  logic [31:0]              hrdata_q;
  logic                     xfer;
  logic [`NUM_FAULTS-1:0]   log_clr;

  // only the low byte of the address is decoded; the map repeats above it
  assign xfer = hsel_in & htrans_in[1] & hready_in;

  always_ff @(posedge mclk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= 8'h00;
    end else begin
      wr_pend_q <= xfer & hwrite_in;
      wr_addr_q <= {haddr_in[7:2], 2'b00};
    end
  end

  always_ff @(posedge mclk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      ctrl_q <= `CTRL_RST;
    end else if (wr_pend_q && wr_addr_q == `OFS_CTRL) begin
      ctrl_q <= hwdata_in[2:0];
    end
  end

  always_ff @(posedge mclk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      policy_q <= `POLICY_RST; // R7 R8
    end else if (wr_pend_q && wr_addr_q == `OFS_POLICY) begin
      policy_q <= hwdata_in[`NUM_POLICY-1:0];
    end
  end

  // sticky log of every fault seen; write one to clear, a new fault wins
  assign log_clr = (wr_pend_q && wr_addr_q == `OFS_LOG) ?
                   hwdata_in[`NUM_FAULTS-1:0] : '0;

  always_ff @(posedge mclk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      log_q <= '0;
    end else begin
      log_q <= (log_q & ~log_clr) | fault_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // classification

  logic      major_f;
  logic      fixed_mod_f;
  logic      fixed_min_f;
  logic [`NUM_POLICY-1:0] cfg_f;
  logic      cfg_mod_f;
  logic      cfg_min_f;
  logic      pwr_f;
  severity_t sev;

  assign major_f     = fault_q[`FLT_CPU] | fault_q[`FLT_MEM_CRASH]; // R1
  assign fixed_mod_f = fault_q[`FLT_MEM_ERR] | fault_q[`FLT_COPROC] | // R3
                       fault_q[`FLT_STARTUP] | fault_q[`FLT_INVALID_INSN] |
                       fault_q[`FLT_IO_POINTS] | fault_q[`FLT_PLUGIN_MEM] |
                       fault_q[`FLT_INTERRUPT];
  assign pwr_f       = fault_q[`FLT_POWER_FAIL];
  assign fixed_min_f = fault_q[`FLT_IPC] | fault_q[`FLT_LINK] | // R1
                       fault_q[`FLT_TX_SWITCH] | pwr_f;
  assign cfg_f       = {fault_q[`FLT_SUBUNIT_COMM],
                        fault_q[`FLT_SUBROUTINE:`FLT_PROGRAM]};
  // stop makes the fault moderate, run makes it minor
  assign cfg_mod_f   = |(cfg_f & ~policy_q); // R6
  assign cfg_min_f   = |(cfg_f & policy_q); // R6

  // the most severe active fault decides everything downstream
  always_comb begin
    if (major_f) begin
      sev = SEV_MAJOR; // R11
    end else if (fixed_mod_f || cfg_mod_f) begin
      sev = SEV_MODERATE;
    end else if (fixed_min_f || cfg_min_f) begin
      sev = SEV_MINOR;
    end else begin
      sev = SEV_NONE;
    end
  end

  function automatic out_action_t setting(input logic hold);
    setting = hold ? ACT_HOLD : ACT_RESET;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // indicator outputs

  indicator_t ind_d;
  indicator_t ind_q;

  always_comb begin
    ind_d                 = '0;
    ind_d.ready_lamp      = (sev != SEV_MAJOR); // R2
    ind_d.fault_lamp      = (sev == SEV_MODERATE); // R2
    ind_d.warning_lamp    = (sev == SEV_MINOR); // R2
    ind_d.fault_contact_a = 1'b0;
    ind_d.fault_contact_b = 1'b1;
    ind_d.ord_action      = ACT_CONTINUE;
    ind_d.adv_action      = ACT_CONTINUE;
    case (sev)
      SEV_MAJOR: begin
        ind_d.fault_contact_a = 1'b1; // R4
        ind_d.fault_contact_b = 1'b0;
        ind_d.ord_action      = setting(ctrl_q[`CTRL_ORD_HOLD]); // R5
        ind_d.adv_action      = ACT_HOLD; // R5
      end
      SEV_MODERATE: begin
        ind_d.fault_contact_a = 1'b1; // R4
        ind_d.fault_contact_b = 1'b0;
        ind_d.ord_action      = setting(ctrl_q[`CTRL_ORD_HOLD]); // R5
        ind_d.adv_action      = setting(ctrl_q[`CTRL_ADV_HOLD]); // R5
      end
      SEV_MINOR: begin
        // power failure overrides the plain minor behaviour per mode
        if (pwr_f && ctrl_q[`CTRL_IMMEDIATE]) begin
          ind_d.fault_contact_a = 1'b1; // R10
          ind_d.fault_contact_b = 1'b0;
          ind_d.ord_action      = ACT_RESET;
          ind_d.adv_action      = ACT_HOLD;
        end else if (pwr_f) begin
          ind_d.ord_action      = ACT_HOLD; // R9
          ind_d.adv_action      = ACT_HOLD;
        end
      end
      default: begin
      end
    endcase
  end

  always_ff @(posedge mclk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      ind_q <= '{ready_lamp: 1'b1, fault_lamp: 1'b0, warning_lamp: 1'b0,
                 fault_contact_a: 1'b0, fault_contact_b: 1'b1,
                 ord_action: ACT_CONTINUE, adv_action: ACT_CONTINUE};
    end else begin
      ind_q <= ind_d;
    end
  end

  assign indicators_out = ind_q;

  ////////////////////////////////////////////////////////////////////////////
  // read data, registered in the address phase so it stands in the data phase

  always_ff @(posedge mclk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      hrdata_q <= 32'h0000_0000;
    end else if (xfer && !hwrite_in) begin
      case ({haddr_in[7:2], 2'b00})
        `OFS_CTRL:   hrdata_q <= {29'h0, ctrl_q};
        `OFS_POLICY: hrdata_q <= {25'h0, policy_q};
        `OFS_STATUS: hrdata_q <= {20'h0, ind_q, 1'b0, sev};
        `OFS_FAULTS: hrdata_q <= {12'h0, fault_q};
        `OFS_LOG:    hrdata_q <= {12'h0, log_q};
        default:     hrdata_q <= 32'h0000_0000;
      endcase
    end
  end

  // zero wait states, always okay
  assign hrdata_out    = hrdata_q;
  assign hreadyout_out = 1'b1;
  assign hresp_out     = 1'b0;

  ////////////////////////////////////////////////////////////////////////////
  // checks

  chk_cpu_major: assert property ( // R1
    @(posedge mclk_in) disable iff (sys_rst_in)
    fault_q[`FLT_CPU] |-> sev == SEV_MAJOR)
    else $error("cpu failure not classed major");

  chk_link_minor: assert property ( // R1
    @(posedge mclk_in) disable iff (sys_rst_in)
    (fault_q == (`NUM_FAULTS'(1) << `FLT_LINK)) |=> indicators_out.warning_lamp
      && indicators_out.ready_lamp && !indicators_out.fault_lamp)
    else $error("link error alone not shown as minor");

  chk_major_lamp: assert property ( // R2
    @(posedge mclk_in) disable iff (sys_rst_in)
    major_f |=> !indicators_out.ready_lamp)
    else $error("ready lamp stayed on during major fault");

  chk_fixed_moderate: assert property ( // R3
    @(posedge mclk_in) disable iff (sys_rst_in)
    (fault_q[`FLT_COPROC] && !major_f) |=> indicators_out.fault_lamp)
    else $error("coprocessor error did not light fault lamp");

  chk_contacts_severe: assert property ( // R4
    @(posedge mclk_in) disable iff (sys_rst_in)
    (sev == SEV_MAJOR || sev == SEV_MODERATE) |=>
      indicators_out.fault_contact_a && !indicators_out.fault_contact_b)
    else $error("contacts wrong for major or moderate fault");

  chk_major_outputs: assert property ( // R5
    @(posedge mclk_in) disable iff (sys_rst_in)
    major_f |=> indicators_out.adv_action == ACT_HOLD &&
      indicators_out.ord_action ==
        ($past(ctrl_q[`CTRL_ORD_HOLD]) ? ACT_HOLD : ACT_RESET))
    else $error("output actions wrong for major fault");

  chk_policy_stop: assert property ( // R6
    @(posedge mclk_in) disable iff (sys_rst_in)
    (fault_q[`FLT_SCAN_TIMEOUT] && !policy_q[4] && !major_f) |->
      sev == SEV_MODERATE)
    else $error("stop policy did not give moderate");

  chk_policy_defaults: assert property ( // R7 R8
    @(posedge mclk_in) disable iff (sys_rst_in)
    $fell(sys_rst_in) |-> policy_q == `POLICY_RST)
    else $error("policy reset value wrong");

  chk_pf_standard: assert property ( // R9
    @(posedge mclk_in) disable iff (sys_rst_in)
    (sev == SEV_MINOR && pwr_f && !ctrl_q[`CTRL_IMMEDIATE]) |=>
      !indicators_out.fault_contact_a && indicators_out.fault_contact_b &&
      indicators_out.ord_action == ACT_HOLD &&
      indicators_out.adv_action == ACT_HOLD)
    else $error("standard mode power failure handling wrong");

  chk_pf_immediate: assert property ( // R10
    @(posedge mclk_in) disable iff (sys_rst_in)
    (sev == SEV_MINOR && pwr_f && ctrl_q[`CTRL_IMMEDIATE]) |=>
      indicators_out.fault_contact_a && !indicators_out.fault_contact_b &&
      indicators_out.ord_action == ACT_RESET &&
      indicators_out.adv_action == ACT_HOLD)
    else $error("immediate mode power failure handling wrong");

  chk_most_severe: assert property ( // R11
    @(posedge mclk_in) disable iff (sys_rst_in)
    (major_f && fixed_mod_f && pwr_f) |=> !indicators_out.fault_lamp &&
      !indicators_out.warning_lamp && indicators_out.fault_contact_a)
    else $error("mixed faults not driven by the most severe");

  chk_log_sticky: assert property (
    @(posedge mclk_in) disable iff (sys_rst_in)
    fault_q[`FLT_LINK] |=> log_q[`FLT_LINK])
    else $error("fault log lost a set");

  chk_moderate_lamp: assert property ( // R2
    @(posedge mclk_in) disable iff (sys_rst_in)
    sev == SEV_MODERATE |=> indicators_out.fault_lamp && indicators_out.ready_lamp &&
      !indicators_out.warning_lamp)
    else $error("moderate fault not shown on the red lamp alone");

  chk_idle_outputs: assert property ( // R2 R4
    @(posedge mclk_in) disable iff (sys_rst_in)
    sev == SEV_NONE |=> indicators_out.ready_lamp && !indicators_out.fault_lamp &&
      !indicators_out.warning_lamp && !indicators_out.fault_contact_a &&
      indicators_out.fault_contact_b)
    else $error("idle indication wrong with no fault present");

  chk_plugin_moderate: assert property ( // R3
    @(posedge mclk_in) disable iff (sys_rst_in)
    (fault_q[`FLT_PLUGIN_MEM] && !major_f) |-> sev == SEV_MODERATE)
    else $error("plug-in memory error not classed moderate");

  chk_tx_switch_minor: assert property ( // R1
    @(posedge mclk_in) disable iff (sys_rst_in)
    (fault_q == (`NUM_FAULTS'(1) << `FLT_TX_SWITCH)) |-> sev == SEV_MINOR)
    else $error("transmitter switchover alone not classed minor");

  chk_minor_contacts: assert property ( // R4 R5
    @(posedge mclk_in) disable iff (sys_rst_in)
    (sev == SEV_MINOR && !pwr_f) |=> !indicators_out.fault_contact_a &&
      indicators_out.fault_contact_b && indicators_out.ord_action == ACT_CONTINUE &&
      indicators_out.adv_action == ACT_CONTINUE)
    else $error("minor fault did not keep contacts and outputs running");

  chk_moderate_outputs: assert property ( // R5
    @(posedge mclk_in) disable iff (sys_rst_in)
    sev == SEV_MODERATE |=>
      indicators_out.ord_action == ($past(ctrl_q[`CTRL_ORD_HOLD]) ? ACT_HOLD : ACT_RESET) &&
      indicators_out.adv_action == ($past(ctrl_q[`CTRL_ADV_HOLD]) ? ACT_HOLD : ACT_RESET))
    else $error("output actions wrong for moderate fault");

  chk_subunit_run: assert property ( // R8
    @(posedge mclk_in) disable iff (sys_rst_in)
    (fault_q == (`NUM_FAULTS'(1) << `FLT_SUBUNIT_COMM) && policy_q[`NUM_POLICY-1]) |->
      sev == SEV_MINOR)
    else $error("subunit communication error under run policy not minor");

  // a clear with no fault behind it must really drop the bit
  chk_log_clear: assert property (
    @(posedge mclk_in) disable iff (sys_rst_in)
    (log_clr[`FLT_LINK] && !fault_q[`FLT_LINK]) |=> !log_q[`FLT_LINK])
    else $error("fault log bit not cleared");

endmodule

`default_nettype wire

/* rtl/fault_sev_defs.svh */
// Summary of operation
// R1: every detected fault is sorted as major, moderate or minor; cpu failure and memory corruption are always major, processor communication, link errors and transmitter switchover are minor.
// R2: a major fault turns the green ready lamp off, a moderate fault lights the red fault lamp and a minor fault lights the yellow warning_lamp.
// R3: memory error, sequence_coprocessor error, startup error, invalid instruction, too many i/o points and plug-in program memory error are moderate.
// R4: major or moderate faults close fault_contact_a and open fault_contact_b against contact_return, minor faults do the opposite.
// R5: on major faults ordinary outputs take their module setting (default reset) and advanced relays hold; on moderate both take their setting (default reset); on minor they continue.
// R6: a fault with a stop/run policy is moderate when set to stop and minor when set to run.
// R7: the policy defaults to stop for program, i/o comparison, i/o module, instruction, scan timeout and subroutine errors.
// R8: the policy for subunit communication errors defaults to run, so that fault is minor unless reconfigured.
// R9: in standard detection mode a momentary power failure opens contact a, closes contact b and holds both output kinds.
// R10: in immediate detection mode a momentary power failure closes contact a, opens contact b, resets ordinary outputs and holds advanced relays.
// R11: with several severities present at once, lamps, contacts and output actions follow the most severe one.
`ifndef FAULT_SEV_DEFS_SVH
`define FAULT_SEV_DEFS_SVH

// fault detector input positions
`define NUM_FAULTS       20
`define FLT_CPU          0
`define FLT_MEM_CRASH    1
`define FLT_MEM_ERR      2
`define FLT_COPROC       3
`define FLT_STARTUP      4
`define FLT_INVALID_INSN 5
`define FLT_IO_POINTS    6
`define FLT_PLUGIN_MEM   7
`define FLT_PROGRAM      8
`define FLT_IO_COMPARE   9
`define FLT_IO_MODULE    10
`define FLT_INSN_ERR     11
`define FLT_SCAN_TIMEOUT 12
`define FLT_SUBROUTINE   13
`define FLT_INTERRUPT    14
`define FLT_SUBUNIT_COMM 15
`define FLT_IPC          16
`define FLT_LINK         17
`define FLT_TX_SWITCH    18
`define FLT_POWER_FAIL   19

// register byte offsets
`define OFS_CTRL   8'h00
`define OFS_POLICY 8'h04
`define OFS_STATUS 8'h08
`define OFS_FAULTS 8'h0c
`define OFS_LOG    8'h10

// ctrl fields
`define CTRL_IMMEDIATE 0
`define CTRL_ORD_HOLD  1
`define CTRL_ADV_HOLD  2
`define CTRL_RST       3'h0

// policy: one run bit per configurable fault, program error at bit 0 up to
// subroutine at bit 5, subunit communication at bit 6
`define NUM_POLICY  7
`define POLICY_RST  7'h40

`endif

/* rtl/fault_sev_pkg.sv */
package fault_sev_pkg;

  typedef enum logic [1:0] {
    SEV_NONE     = 2'b00,
    SEV_MINOR    = 2'b01,
    SEV_MODERATE = 2'b10,
    SEV_MAJOR    = 2'b11
  } severity_t;

  typedef enum logic [1:0] {
    ACT_CONTINUE = 2'b00,
    ACT_HOLD     = 2'b01,
    ACT_RESET    = 2'b10
  } out_action_t;

  typedef struct packed {
    logic        ready_lamp;
    logic        fault_lamp;
    logic        warning_lamp;
    logic        fault_contact_a;
    logic        fault_contact_b;
    out_action_t ord_action;
    out_action_t adv_action;
  } indicator_t;

endpackage

/* tb/output_module_model.sv */
`timescale 1ns/1ps
`default_nettype none

module output_module_model
  import fault_sev_pkg::*;
(
  // clock and reset
  input  wire logic       mclk_in,
  input  wire logic       sys_rst_in,
  // command from the indicator block and program drive
  input  wire indicator_t indicators_in,
  input  wire logic       prog_in,
  // output point levels
  output logic            ord_level_out,
  output logic            adv_level_out
);
  // an output that holds keeps its last level even when the program drive moves
  function automatic logic next_level(input out_action_t act, input logic cur, input logic prog);
    if (act == ACT_RESET) begin
      return 1'b0;
    end
    if (act == ACT_HOLD) begin
      return cur;
    end
    return prog;
  endfunction

  always_ff @(posedge mclk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      ord_level_out <= 1'b0;
      adv_level_out <= 1'b0;
    end else begin
      ord_level_out <= next_level(indicators_in.ord_action, ord_level_out, prog_in);
      adv_level_out <= next_level(indicators_in.adv_action, adv_level_out, prog_in);
    end
  end
endmodule

`default_nettype wire

/* tb/fault_severity_indicator_bench.sv */
`timescale 1ns/1ps
`default_nettype none
`include "fault_sev_defs.svh"

module fault_severity_indicator_bench
  import fault_sev_pkg::*;
;
  logic        mclk_in;
  logic        sys_rst_in;
  logic        hsel_in;
  logic [31:0] haddr_in;
  logic [1:0]  htrans_in;
  logic        hwrite_in;
  logic [31:0] hwdata_in;
  logic [31:0] hrdata_out;
  logic        hreadyout_out;
  logic        hresp_out;
  logic [19:0] fault_in;
  indicator_t  indicators_out;
  logic        prog_drive;
  logic        ord_level;
  logic        adv_level;
  logic [2:0]  ctrl_now;
  logic [6:0]  pol_now;
  logic [31:0] rd_word;
  int          err_total;
  int          tests_run;

  fault_severity_indicator fault_severity_indicator_inst (
    .mclk_in(mclk_in), .sys_rst_in(sys_rst_in), .hsel_in(hsel_in), .haddr_in(haddr_in),
    .htrans_in(htrans_in), .hwrite_in(hwrite_in), .hsize_in(3'h2), .hwdata_in(hwdata_in),
    .hready_in(hreadyout_out), .hrdata_out(hrdata_out), .hreadyout_out(hreadyout_out),
    .hresp_out(hresp_out), .fault_in(fault_in), .indicators_out(indicators_out));

  output_module_model output_module_model_inst (
    .mclk_in(mclk_in), .sys_rst_in(sys_rst_in), .indicators_in(indicators_out),
    .prog_in(prog_drive), .ord_level_out(ord_level), .adv_level_out(adv_level));

  initial begin
    mclk_in = 1'b0;
    forever #10 mclk_in = ~mclk_in;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_total++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // entered just after a rising edge; waits on hready, no fixed latency assumed
  task automatic ahb_xfer(input logic wr, input logic [7:0] addr, input logic [31:0] wdata,
                          output logic [31:0] rdata);
    hsel_in <= 1'b1;
    haddr_in <= {24'h0, addr};
    htrans_in <= 2'b10;
    hwrite_in <= wr;
    @(posedge mclk_in);
    while (hreadyout_out !== 1'b1) @(posedge mclk_in);
    htrans_in <= 2'b00;
    hwdata_in <= wdata;
    @(posedge mclk_in);
    while (hreadyout_out !== 1'b1) @(posedge mclk_in);
    rdata = hrdata_out;
  endtask

  task automatic rd_chk(input logic [7:0] addr, input logic [31:0] exp);
    logic [31:0] r;
    ahb_xfer(1'b0, addr, 32'h0, r);
    chk(r, exp);
    chk({31'h0, hresp_out}, 32'h0);
  endtask

  task automatic set_ctrl(input logic [2:0] c);
    logic [31:0] r;
    ctrl_now = c;
    ahb_xfer(1'b1, `OFS_CTRL, {29'h0, c}, r);
  endtask

  task automatic set_pol(input logic [6:0] p);
    logic [31:0] r;
    pol_now = p;
    ahb_xfer(1'b1, `OFS_POLICY, {25'h0, p}, r);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  function automatic indicator_t exp_ind(input logic [19:0] f, input logic [2:0] c,
                                         input logic [6:0] p);
    out_action_t ord;
    out_action_t adv;
    ord = c[1] ? ACT_HOLD : ACT_RESET;
    adv = c[2] ? ACT_HOLD : ACT_RESET;
    if (f[1:0] != 2'h0) return '{1'b0, 1'b0, 1'b0, 1'b1, 1'b0, ord, ACT_HOLD};
    if (f[7:2] != 6'h0 || f[14] || (f[13:8] & ~p[5:0]) != 6'h0 || (f[15] & ~p[6]))
      return '{1'b1, 1'b1, 1'b0, 1'b1, 1'b0, ord, adv};
    if (f[19] && c[0]) return '{1'b1, 1'b0, 1'b1, 1'b1, 1'b0, ACT_RESET, ACT_HOLD};
    if (f[19]) return '{1'b1, 1'b0, 1'b1, 1'b0, 1'b1, ACT_HOLD, ACT_HOLD};
    if (f[18:15] != 4'h0 || f[13:8] != 6'h0)
      return '{1'b1, 1'b0, 1'b1, 1'b0, 1'b1, ACT_CONTINUE, ACT_CONTINUE};
    return '{1'b1, 1'b0, 1'b0, 1'b0, 1'b1, ACT_CONTINUE, ACT_CONTINUE};
  endfunction

  // fault levels need three edges to reach the outputs; four leaves margin
  task automatic run_case(input logic [19:0] f);
    indicator_t e;
    logic [31:0] sev;
    e = exp_ind(f, ctrl_now, pol_now);
    sev = !e.ready_lamp ? 32'h3 : e.fault_lamp ? 32'h2 : {31'h0, e.warning_lamp};
    fault_in <= f;
    repeat (4) @(posedge mclk_in);
    chk(32'(indicators_out), 32'(e));
    rd_chk(`OFS_STATUS, {20'h0, e, 1'b0, sev[1:0]});
    rd_chk(`OFS_FAULTS, {12'h0, f});
  endtask

  task automatic close_out();
    $display("comparisons %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    #400000;
    err_total++;
    close_out();
  end

  initial begin
    sys_rst_in = 1'b1;
    hsel_in = 1'b0;
    haddr_in = 32'h0;
    htrans_in = 2'b00;
    hwrite_in = 1'b0;
    hwdata_in = 32'h0;
    fault_in = 20'h0;
    prog_drive = 1'b0;
    ctrl_now = 3'h0;
    pol_now = 7'h40;
    err_total = 0;
    tests_run = 0;
    repeat (4) @(posedge mclk_in);
    sys_rst_in <= 1'b0;
    @(posedge mclk_in);
    chk(32'(indicators_out), 32'h110);
    rd_chk(`OFS_CTRL, 32'h0);
    rd_chk(`OFS_POLICY, 32'h40);
    rd_chk(8'h14, 32'h0);
    for (int i = 0; i < 20; i++) run_case(20'h1 << i);
    set_pol(7'h3f);
    rd_chk(`OFS_POLICY, 32'h3f);
    for (int i = 8; i < 16; i++) run_case(20'h1 << i);
    set_pol(7'h00);
    for (int i = 8; i < 16; i++) run_case(20'h1 << i);
    set_pol(7'h40);
    for (int k = 0; k < 8; k++) begin
      set_ctrl(3'(k));
      rd_chk(`OFS_CTRL, {29'h0, 3'(k)});
      run_case(20'h00001);
      run_case(20'h00004);
      run_case(20'h80000);
      run_case(20'h80004);
      run_case(20'h70002);
      run_case(20'h0);
    end
    // held outputs must ignore the program drive during a power dip
    set_ctrl(3'h0);
    prog_drive <= 1'b1;
    run_case(20'h0);
    run_case(20'h80000);
    prog_drive <= 1'b0;
    repeat (2) @(posedge mclk_in);
    chk({30'h0, ord_level, adv_level}, 32'h3);
    set_ctrl(3'h1);
    run_case(20'h80000);
    chk({30'h0, ord_level, adv_level}, 32'h1);
    // every fault has been seen once; a clear keeps the one still present
    rd_chk(`OFS_LOG, 32'h000f_ffff);
    ahb_xfer(1'b1, `OFS_LOG, 32'h000f_ffff, rd_word);
    rd_chk(`OFS_LOG, 32'h0008_0000);
    // a reset in mid-run must bring back the idle indication and the defaults
    set_pol(7'h15);
    sys_rst_in <= 1'b1;
    fault_in <= 20'h0;
    repeat (2) @(posedge mclk_in);
    sys_rst_in <= 1'b0;
    @(posedge mclk_in);
    chk(32'(indicators_out), 32'h110);
    rd_chk(`OFS_CTRL, 32'h0);
    rd_chk(`OFS_POLICY, 32'h40);
    rd_chk(`OFS_LOG, 32'h0);
    close_out();
  end
endmodule

`default_nettype wire
